/* logic/qcc_cal_if.sv */
/*
 * Link between the register side of the block and its delay search.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

interface qcc_cal_if;
    import qcc_pkg::*;
    logic               start;
    logic               abort;
    logic               busy;
    logic               done;
    logic [DELAY_W-1:0] trial;
    logic [DELAY_W-1:0] result_count;
    logic               result_half;
    logic               past_quarter;
    logic               past_half;

    modport ctrl (output start, abort, past_quarter, past_half,
                  input  busy, done, trial, result_count, result_half);
    modport search (input  start, abort, past_quarter, past_half,
                    output busy, done, trial, result_count, result_half);
endinterface

`default_nettype wire

/* logic/qcc_delay_search.sv */
/*
 * Successive-approximation search for the delay-element count that puts
 * the quadrature clock at a quarter turn behind the in-phase clock.
 * Assumes synchronised phase-detector samples on the interface.
 */
`timescale 1ns/1ps
`default_nettype none

module qcc_delay_search
    import qcc_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     rst_n,
    qcc_cal_if.search     cal
);
    localparam int SEARCH_MIN = 1;
    localparam int SEARCH_MAX = 60;

    qcc_state_t         state_r;
    qcc_state_t         state_nxt;
    logic [3:0]         settle_r;
    logic [2:0]         bit_r;
    logic [DELAY_W-1:0] trial_r;
    logic [DELAY_W-1:0] result_r;
    logic               half_r;
    logic               done_r;

    // ==========================================================
    // Decision per bit
    wire logic [DELAY_W-1:0] mask       = DELAY_W'(1) << bit_r;
    wire logic               settled    = (settle_r == 4'h0);
    // Keep the bit only while the shift has not yet passed a quarter turn
    wire logic [DELAY_W-1:0] decided    = cal.past_quarter ? (trial_r & ~mask) : trial_r;
    wire logic               last_bit   = (bit_r == 3'h0);
    wire logic               probe_step = (state_r == QCC_PROBE) && settled && !cal.abort;
    wire logic               final_step = (state_r == QCC_FINAL) && settled && !cal.abort;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            QCC_IDLE:  if (cal.start) state_nxt = QCC_PROBE;
            QCC_PROBE: begin
                if (cal.abort) state_nxt = QCC_IDLE;
                else if (probe_step && last_bit) state_nxt = QCC_FINAL;
            end
            QCC_FINAL: if (cal.abort || final_step) state_nxt = QCC_IDLE;
            default:   state_nxt = QCC_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r  <= QCC_IDLE;
            settle_r <= 4'h0;
            bit_r    <= 3'h0;
            trial_r  <= DELAY_RST;
            result_r <= DELAY_RST;
            half_r   <= 1'b0;
            done_r   <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            done_r   <= final_step;
            settle_r <= (state_r != state_nxt || probe_step) ? SETTLE_CNT
                      : (settled ? settle_r : settle_r - 4'h1);
            if (state_r == QCC_IDLE && cal.start) begin
                trial_r <= DELAY_MSB;
                bit_r   <= MSB_INDEX;
            end else if (probe_step) begin
                trial_r <= last_bit ? decided : (decided | (mask >> 1));
                bit_r   <= last_bit ? bit_r : bit_r - 3'h1;
            end
            if (final_step) begin
                result_r <= trial_r;
                half_r   <= cal.past_half;
            end
        end
    end

    assign cal.busy         = (state_r != QCC_IDLE);
    assign cal.done         = done_r;
    assign cal.trial        = trial_r;
    assign cal.result_count = result_r;
    assign cal.result_half  = half_r;

    // ==========================================================
    // Checks
    sequence s_search_start;
        (state_r == QCC_IDLE) && cal.start;
    endsequence

    sequence s_search_end;
        ##[SEARCH_MIN:SEARCH_MAX] cal.done;
    endsequence

    a_search_completes: assert property (@(posedge clk) disable iff (!rst_n)
        s_search_start ##1 !cal.abort [*4] |-> s_search_end or ##[1:60] cal.abort)
        else $error("delay search did not finish in time");

    a_result_on_done: assert property (@(posedge clk) disable iff (!rst_n)
        cal.done |-> cal.result_count == $past(trial_r) && !cal.busy)
        else $error("search result not taken from final trial");
endmodule

`default_nettype wire

/* logic/qcc_pkg.sv */
/*
 * Constants and types for the quadrature clock calibration block.
 * Assumes a 20 MHz core clock and a 32-bit Avalon-MM register bus.
 */
package qcc_pkg;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 50;
    // Settling of the analog delay chain and phase detector
    localparam int SETTLE_TIME_NS = 200;
    localparam int SYNC_STAGES    = 2;
    // Least time rounds up; the synchroniser latency is added on top
    localparam int SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
                                    + SYNC_STAGES;
    localparam logic [3:0] SETTLE_CNT = 4'(SETTLE_CYC - 1);

    // ==========================================================
    // Register map (printed offsets are indices, byte address = 4 * index)
    localparam int          ADDR_W       = 8;
    localparam int          DATA_W       = 32;
    localparam logic [5:0]  CTRL_INDEX   = 6'h1f;
    localparam logic [5:0]  RXSEL_INDEX  = 6'h20;

    // ==========================================================
    // Fields of quadrature_clock_control
    localparam int          DELAY_W      = 5;
    localparam int          FLAG_BIT     = 7;
    localparam int          DIS_BIT      = 6;
    localparam int          SPARE_BIT    = 5;
    localparam int          RXSEL_BIT    = 0;
    localparam logic [4:0]  DELAY_RST    = 5'h00;
    localparam logic [4:0]  DELAY_MSB    = 5'h10;
    localparam logic [2:0]  MSB_INDEX    = 3'h4;
    localparam logic        RXSEL_RST    = 1'b1;

    typedef enum {QCC_IDLE, QCC_PROBE, QCC_FINAL} qcc_state_t;

endpackage

/* logic/qcc_top.sv */
/*
 * Quadrature clock control: one register that reports the delay-element
 * count and the above-half-turn flag, and automatic calibration after
 * reset and after each card reception. A second register holds the
 * receiver clock select. Reached over Avalon-MM with waitrequest.
 * Assumes the phase-detector levels are asynchronous to clk and that
 * the receiver pulses rx_done for one clk cycle in this domain.
 */
// Overview of operation
// - Register at index 1Fh; upper bits reset zero
// - Bit 7 shows shift beyond half turn
// - Bit 6 low: calibrate after reset, reception
// - Bit 6 high: no calibration, count held
// - Bits 4:0 report applied delay-element count
// - Quadrature clock nominally quarter turn behind
// - Receiver select: 1 in-phase, 0 quadrature
`timescale 1ns/1ps
`default_nettype none

module qcc_top
    import qcc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              rx_done,
    input  wire logic              phase_past_quarter,
    input  wire logic              phase_past_half,
    output logic      [DELAY_W-1:0] delay_chain_count,
    output logic                   receiver_clock_select
);

    // ==========================================================
    // Reset and input synchronisers
    logic rst_meta_r;
    logic rst_n_s;
    logic pq_meta_r;
    logic pq_sync_r;
    logic ph_meta_r;
    logic ph_sync_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_n_s    <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_s    <= rst_meta_r;
        end
    end

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pq_meta_r <= 1'b0;
            pq_sync_r <= 1'b0;
            ph_meta_r <= 1'b0;
            ph_sync_r <= 1'b0;
        end else begin
            pq_meta_r <= phase_past_quarter;
            pq_sync_r <= pq_meta_r;
            ph_meta_r <= phase_past_half;
            ph_sync_r <= ph_meta_r;
        end
    end

    // ==========================================================
    // Register state
    logic               half_flag_r;
    logic               cal_disable_r;
    logic               spare_r;
    logic [DELAY_W-1:0] count_r;
    logic               rx_sel_r;
    logic [DELAY_W-1:0] chain_r;
    logic               pending_r;
    logic               start_r;
    logic               wait_r;
    logic [DATA_W-1:0]  rdata_r;

    qcc_cal_if cal ();

    qcc_delay_search u_search (
        .clk   (clk),
        .rst_n (rst_n_s),
        .cal   (cal.search)
    );

    assign cal.start        = start_r;
    // Disabling mid-search drops it; the reported count stays and the chain returns to it
    assign cal.abort        = cal_disable_r;
    assign cal.past_quarter = pq_sync_r;
    assign cal.past_half    = ph_sync_r;

    // ==========================================================
    // Avalon-MM decode: one wait cycle on every access
    wire logic       hit_ctrl  = (avs_address[ADDR_W-1:2] == CTRL_INDEX);
    wire logic       hit_rxsel = (avs_address[ADDR_W-1:2] == RXSEL_INDEX);
    wire logic       req       = avs_read || avs_write;
    wire logic       commit    = req && !wait_r;
    wire logic       lane0     = avs_byteenable[0];
    wire logic       wr_ctrl   = avs_write && commit && hit_ctrl && lane0;
    wire logic       wr_rxsel  = avs_write && commit && hit_rxsel && lane0;
    wire logic [7:0] ctrl_view = {half_flag_r, cal_disable_r, spare_r, count_r};
    wire logic [DATA_W-1:0] rd_mux =
        hit_ctrl  ? {24'h00_0000, ctrl_view} :
        hit_rxsel ? {31'h0000_0000, rx_sel_r} : 32'h0000_0000;

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
        end else begin
            wait_r <= !(req && wait_r);
            if (req && wait_r) rdata_r <= rd_mux;
        end
    end

    // ==========================================================
    // Control and status fields
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            cal_disable_r <= 1'b0;
            spare_r       <= 1'b0;
            rx_sel_r      <= RXSEL_RST;
        end else begin
            if (wr_ctrl) begin
                cal_disable_r <= avs_writedata[DIS_BIT];
                // Stored as written; software is expected to keep it zero
                spare_r       <= avs_writedata[SPARE_BIT];
            end
            if (wr_rxsel) rx_sel_r <= avs_writedata[RXSEL_BIT];
        end
    end

    // Count and flag move only on a finished search, and together
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            count_r     <= DELAY_RST;
            half_flag_r <= 1'b0;
        end else if (cal.done) begin
            count_r     <= cal.result_count;
            half_flag_r <= cal.result_half;
        end
    end

    // The chain sees trial values while searching, else the reported count
    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            chain_r <= DELAY_RST;
        end else begin
            chain_r <= cal.busy ? cal.trial : (cal.done ? cal.result_count : count_r);
        end
    end

    // ==========================================================
    // Calibration triggers
    // Pending resets high so the end of the reset phase starts a search.
    // A reception in the cycle the pending request is taken still counts.
    wire logic launch = pending_r && !cal_disable_r && !cal.busy && !start_r;

    always_ff @(posedge clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            pending_r <= 1'b1;
            start_r   <= 1'b0;
        end else begin
            start_r <= launch;
            if (rx_done && !cal_disable_r) pending_r <= 1'b1;
            else if (launch || cal_disable_r) pending_r <= 1'b0;
        end
    end

    assign avs_waitrequest       = wait_r;
    assign avs_readdata          = rdata_r;
    assign delay_chain_count     = chain_r;
    assign receiver_clock_select = rx_sel_r;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_s);

    sequence s_ctrl_read;
        avs_read && commit && hit_ctrl;
    endsequence

    sequence s_rxsel_write;
        wr_rxsel;
    endsequence

    a_reset_upper_zero: assert property (
        $rose(rst_n_s) |-> !half_flag_r && !cal_disable_r && !spare_r)
        else $error("upper control bits not zero after reset");

    a_flag_with_count: assert property (
        cal.done |=> half_flag_r == $past(cal.result_half)
                     && count_r == $past(cal.result_count))
        else $error("flag and count not updated together");

    a_auto_start: assert property (
        rx_done && !cal_disable_r && !cal.busy |-> ##[1:3] (cal.busy || cal_disable_r))
        else $error("reception did not start a calibration");

    a_no_start_disabled: assert property (
        cal_disable_r |-> !launch ##1 !cal.done [*2])
        else $error("calibration ran while disabled");

    a_count_held: assert property (
        cal_disable_r && $past(cal_disable_r) && !$past(cal.done) |-> $stable(count_r))
        else $error("delay count changed while calibration disabled");

    a_count_readback: assert property (
        s_ctrl_read |-> avs_readdata[DELAY_W-1:0] == $past(count_r)
                        && avs_readdata[FLAG_BIT] == $past(half_flag_r))
        else $error("read data does not show delay count");

    a_chain_idle_match: assert property (
        !cal.busy && !$past(cal.busy) && !$past(cal.done) |-> delay_chain_count == count_r)
        else $error("delay chain differs from reported count");

    a_rx_select_write: assert property (
        s_rxsel_write |=> receiver_clock_select == $past(avs_writedata[RXSEL_BIT]))
        else $error("receiver clock select not written");

endmodule

`default_nettype wire

/* tb/testbench.sv */
/*
 * Self-checking bench for the quadrature clock control block.
 * Assumes qcc_top as the device, a 20 MHz clock and a phase detector
 * modelled here from the applied delay count.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench
    import qcc_pkg::*;
;
    logic              clk;
    logic              resetn;
    logic [ADDR_W-1:0] avs_address;
    logic              avs_read;
    logic              avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [3:0]        avs_byteenable;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic              rx_done;
    logic              phase_past_quarter;
    logic              phase_past_half;
    logic [DELAY_W-1:0] delay_chain_count;
    logic              receiver_clock_select;
    logic [4:0]        thr;
    logic              half;
    logic [31:0]       rd;
    int                n_fail;
    int                comparisons;
    int                cyc = 0;
    // Rows: {half flag level, last count before the chain passes a quarter turn}
    logic [5:0]        rows [6] = '{6'h09, 6'h00, 6'h1f, 6'h2d, 6'h10, 6'h30};

    qcc_top i_qcc_top (
        .clk                   (clk),
        .resetn                (resetn),
        .avs_address           (avs_address),
        .avs_read              (avs_read),
        .avs_write             (avs_write),
        .avs_writedata         (avs_writedata),
        .avs_byteenable        (avs_byteenable),
        .avs_readdata          (avs_readdata),
        .avs_waitrequest       (avs_waitrequest),
        .rx_done               (rx_done),
        .phase_past_quarter    (phase_past_quarter),
        .phase_past_half       (phase_past_half),
        .delay_chain_count     (delay_chain_count),
        .receiver_clock_select (receiver_clock_select)
    );

    // ==========================================================
    // Clock, phase detector and watchdog
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Detector lags one cycle, well inside the search's settle time
    always @(posedge clk) begin
        phase_past_quarter <= (delay_chain_count > thr);
        phase_past_half    <= half;
        cyc                <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            print_verdict();
        end
    end

    // ==========================================================
    // Tasks
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t reg got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t pin got %h exp %h", $time, got, exp);
        end
    endtask

    // Called just after a rising edge; returns one edge after release
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        int n;
        n = 0;
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= !wr;
        avs_writedata  <= {24'h00_0000, d};
        avs_byteenable <= be;
        do begin
            @(posedge clk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        if (n >= 20) begin
            n_fail = n_fail + 1;
            $display("CHECK FAILED t=%0t bus got %h exp %h", $time, n, 0);
        end
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge clk);
    endtask

    task automatic pulse_rx();
        rx_done <= 1'b1;
        @(posedge clk);
        rx_done <= 1'b0;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        resetn = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hf;
        rx_done = 1'b0;
        thr = 5'h07;
        half = 1'b0;
        n_fail = 0;
        comparisons = 0;
        rd = '0;
        repeat (16) @(posedge clk);
        chk_pin({3'h0, delay_chain_count}, 8'h00);
        chk_pin({7'h00, receiver_clock_select}, 8'h01);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd & 32'hffff_ffe0, 32'h0000_0000);
        repeat (100) @(posedge clk);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_0007);

        // Each row: reception, search, then count and flag read together
        foreach (rows[i]) begin
            thr  <= rows[i][4:0];
            half <= rows[i][5];
            pulse_rx();
            repeat (100) @(posedge clk);
            bus(1'b0, 8'h7c, 8'h00, 4'hf);
            chk_reg(rd, {24'h00_0000, half, 2'b00, thr});
            chk_pin({3'h0, delay_chain_count}, {3'h0, thr});
        end
        // Last row left flag 1, count 10h
        bus(1'b1, 8'h7c, 8'h40, 4'hf);
        thr <= 5'h03;
        half <= 1'b0;
        pulse_rx();
        repeat (100) @(posedge clk);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_00d0);
        chk_pin({3'h0, delay_chain_count}, 8'h10);
        // Flag is read-only; a write without byte 0 is dropped
        bus(1'b1, 8'h7c, 8'h00, 4'he);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_00d0);
        bus(1'b1, 8'h7c, 8'h00, 4'hf);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_0090);
        // Second reception during a search is rerun afterwards
        pulse_rx();
        repeat (6) @(posedge clk);
        thr <= 5'h15;
        pulse_rx();
        repeat (150) @(posedge clk);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_0015);
        // Unmapped place reads zero and ignores writes
        bus(1'b1, 8'h84, 8'hff, 4'hf);
        bus(1'b0, 8'h84, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_0000);
        // Receiver clock select: 0 picks the quadrature clock
        bus(1'b1, 8'h80, 8'h00, 4'hf);
        chk_pin({7'h00, receiver_clock_select}, 8'h00);
        bus(1'b1, 8'h80, 8'h01, 4'hf);
        chk_pin({7'h00, receiver_clock_select}, 8'h01);
        bus(1'b0, 8'h80, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_0001);
        // Mid-run reset restores the fields' reset values (select back to 1) and recalibrates on release
        bus(1'b1, 8'h7c, 8'h40, 4'hf);
        bus(1'b1, 8'h80, 8'h00, 4'hf);
        resetn <= 1'b0;
        repeat (2) @(posedge clk);
        chk_pin({7'h00, receiver_clock_select}, 8'h01);
        chk_pin({3'h0, delay_chain_count}, 8'h00);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd & 32'hffff_ffe0, 32'h0000_0000);
        repeat (100) @(posedge clk);
        bus(1'b0, 8'h7c, 8'h00, 4'hf);
        chk_reg(rd, 32'h0000_0015);
        print_verdict();
    end
endmodule

`default_nettype wire
